// >>> inc/vps_pkg.sv
// package for the valve proving sequencer: register map, field layout,
// timing constants, schedule codes and the valve drive carrier.
// assumes a 200 MHz core clock and an apb slave with 32-bit data.
package vps_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam longint unsigned CLK_PERIOD_PS = 64'd5000;
	localparam longint unsigned PS_PER_S = 64'd1000000000000;
	localparam longint unsigned CYC_PER_SEC = PS_PER_S / CLK_PERIOD_PS;
	localparam logic [11:0] PULSE_S = 12'h004;
	localparam logic [11:0] SETTLE_S = 12'h003;
	localparam int TIME_W = 12;
	localparam logic [11:0] FINE_MAX_S = 12'h03c;
	localparam logic [11:0] MID_MAX_S = 12'h258;
	localparam logic [11:0] COARSE_MAX_S = 12'he10;
	localparam int MID_STEP_S = 10;
	localparam int COARSE_STEP_S = 60;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] TTIME_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
	localparam int CTRL_SCHED_LSB = 0;
	localparam int CTRL_CLR_BIT = 8;
	localparam int IRQ_W = 3;
	localparam int IRQ_LOW_LEAK = 0;
	localparam int IRQ_HIGH_LEAK = 1;
	localparam int IRQ_PASS = 2;
	localparam logic [11:0] TTIME_RST = 12'h000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		VPS_NEVER,
		VPS_BEFORE,
		VPS_AFTER,
		VPS_BOTH,
		VPS_SPLIT
	} vps_sched_e;

	typedef enum logic [3:0] {
		VPS_IDLE,
		VPS_DEPRESS,
		VPS_SETTLE_LO,
		VPS_TEST_LO,
		VPS_PRESS,
		VPS_SETTLE_HI,
		VPS_TEST_HI,
		VPS_RUN,
		VPS_LOCK
	} vps_state_e;

	typedef struct packed {
		logic upstream_valve;
		logic downstream_valve;
	} vps_valve_s;

endpackage : vps_pkg

// >>> verilog/vps_timer.sv
// seconds timer for the valve proving sequencer.
// assumes load is a one-cycle pulse from the sequencer on the same clock.
`timescale 1ns/1ps
module vps_timer
	import vps_pkg::*;
#(
	parameter longint unsigned CYC_SEC = CYC_PER_SEC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [TIME_W-1:0] secs,
	output logic done
);

	localparam int PW = $clog2(CYC_SEC);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_SEC - 64'd1);

	if (CYC_SEC < 64'd2) begin : g_chk
		$error("vps_timer: cycles per second too small");
	end

	logic [PW-1:0] pre_q;
	logic [TIME_W-1:0] left_q;
	logic run_q;

	// ------------------------------------------------------------------
	// prescaler, restarted on load so each second is whole
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
		end else if (load || pre_q == PRE_LAST) begin
			pre_q <= '0;
		end else if (run_q) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// seconds down counter; exact counts, well inside ten percent
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_q <= '0;
			run_q <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				left_q <= secs;
				run_q <= 1'b1;
			end else if (run_q && left_q == '0) begin
				run_q <= 1'b0;
				done <= 1'b1;
			end else if (run_q && pre_q == PRE_LAST) begin
				left_q <= left_q - 1'b1;
			end
		end
	end

endmodule : vps_timer

// >>> verilog/vps_seq.sv
// valve proving sequencer with apb register slave and interrupt.
// assumes demand and pressure switch pins are asynchronous to core_clk;
// lockout is left only by a software clear or by rst.
//
// Operation
// - a commissioning setting picks never, before, after, both or split.
// - the setting resets to never, which runs no seat test.
// - before schedule runs the seat test alongside pre-purge.
// - after schedule tests once run ends, before the safety relay drops.
// - both schedule runs the full test before and after run.
// - split runs high-pressure half before, low-pressure half after.
// - pre-run proving starts only while demand is asserted by the controller.
// - a programmable test duration sets each monitoring phase length.
// - every timed interval stays within ten percent of nominal.
// - depressurize: downstream valve on, upstream off, for 4 seconds.
// - after depressurizing, wait 3 seconds ignoring the pressure switch.
// - low-pressure test locks out if the switch goes active.
// - pressurize: upstream valve on, downstream off, for 4 seconds.
// - after pressurizing, wait 3 seconds ignoring the pressure switch.
// - high-pressure test locks out if the switch goes inactive.
// - duration steps 1 s to 60 s, 10 s to 600 s, 1 min to 60 min; the code also accepts 0 s, which is its reset value.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module vps_seq
	import vps_pkg::*;
#(
	parameter longint unsigned CYC_SEC = CYC_PER_SEC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic demand,
	input wire logic seat_pressure_switch,
	output vps_valve_s valves,
	output logic lockout,
	output logic proving_busy,
	output logic run_permit,
	output logic safety_relay_hold,
	output logic irq
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	localparam int NPIN = 2;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s;
	assign pin_raw = {seat_pressure_switch, demand};

	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		logic [2:0] sh_q;
		logic val_q;
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				sh_q <= 3'h0;
			end else begin
				sh_q <= {sh_q[1:0], pin_raw[i]};
			end
		end
		// only stages two and three vote, stage one feeds stage two only
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				val_q <= 1'b0;
			end else if (sh_q[1] == sh_q[2]) begin
				val_q <= sh_q[2];
			end
		end
		assign pin_s[i] = val_q;
	end

	logic demand_s;
	logic switch_s;
	assign demand_s = pin_s[0];
	assign switch_s = pin_s[1];

	// ------------------------------------------------------------------
	// registers and apb decode
	// ------------------------------------------------------------------
	vps_sched_e sched_q;
	logic [TIME_W-1:0] ttime_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic [31:0] rd_d;
	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic clr_lock;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign clr_lock = wr && paddr == CTRL_OFS && pwdata[CTRL_CLR_BIT];

	always_comb begin
		case (paddr)
			CTRL_OFS, TTIME_OFS, STATUS_OFS, IRQ_STAT_OFS,
			IRQ_MASK_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	function automatic vps_sched_e legal_sched(input logic [2:0] v);
		case (v)
			3'h1: legal_sched = VPS_BEFORE;
			3'h2: legal_sched = VPS_AFTER;
			3'h3: legal_sched = VPS_BOTH;
			3'h4: legal_sched = VPS_SPLIT;
			default: legal_sched = VPS_NEVER;
		endcase
	endfunction : legal_sched

	// snaps a written duration down to the nearest legal step
	function automatic logic [TIME_W-1:0] legal_time(
		input logic [31:0] v
	);
		if (v <= 32'(FINE_MAX_S)) begin
			legal_time = TIME_W'(v);
		end else if (v <= 32'(MID_MAX_S)) begin
			legal_time = TIME_W'((v / MID_STEP_S) * MID_STEP_S);
		end else if (v >= 32'(COARSE_MAX_S)) begin
			legal_time = COARSE_MAX_S;
		end else begin
			legal_time = TIME_W'((v / COARSE_STEP_S) * COARSE_STEP_S);
		end
	endfunction : legal_time

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sched_q <= VPS_NEVER;
		end else if (wr && paddr == CTRL_OFS) begin
			sched_q <= legal_sched(pwdata[CTRL_SCHED_LSB +: 3]);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ttime_q <= TTIME_RST;
		end else if (wr && paddr == TTIME_OFS) begin
			ttime_q <= legal_time(pwdata);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr && paddr == IRQ_MASK_OFS) begin
			irq_mask_q <= pwdata[IRQ_W-1:0];
		end
	end

	// read clears the status; a new event in that cycle still sets
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else if (access && !pwrite && paddr == IRQ_STAT_OFS) begin
			irq_stat_q <= irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------------
	vps_state_e state_q;
	vps_state_e state_d;
	logic after_q;
	logic after_d;
	logic load_d;
	logic [TIME_W-1:0] secs_d;
	logic tmr_done;
	logic [TIME_W-1:0] secs_q;
	logic load_q;

	always_comb begin
		case (paddr)
			CTRL_OFS: rd_d = 32'(sched_q);
			TTIME_OFS: rd_d = 32'(ttime_q);
			STATUS_OFS: rd_d = {20'h00000, run_permit, proving_busy,
				demand_s, switch_s, valves, lockout, after_q, state_q};
			IRQ_STAT_OFS: rd_d = 32'(irq_stat_q);
			IRQ_MASK_OFS: rd_d = 32'(irq_mask_q);
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= rd_d;
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		after_d = after_q;
		load_d = 1'b0;
		secs_d = PULSE_S;
		irq_set = '0;
		case (state_q)
			VPS_IDLE: begin
				if (demand_s) begin
					after_d = 1'b0;
					load_d = 1'b1;
					case (sched_q)
						VPS_BEFORE, VPS_BOTH: state_d = VPS_DEPRESS;
						VPS_SPLIT: state_d = VPS_PRESS;
						default: state_d = VPS_RUN;
					endcase
				end
			end
			VPS_DEPRESS: begin
				if (tmr_done) begin
					state_d = VPS_SETTLE_LO;
					load_d = 1'b1;
					secs_d = SETTLE_S;
				end
			end
			VPS_SETTLE_LO: begin
				if (tmr_done) begin
					state_d = VPS_TEST_LO;
					load_d = 1'b1;
					secs_d = ttime_q;
				end
			end
			VPS_TEST_LO: begin
				if (switch_s) begin
					state_d = VPS_LOCK;
					irq_set[IRQ_LOW_LEAK] = 1'b1;
				end else if (tmr_done && after_q && sched_q == VPS_SPLIT) begin
					state_d = VPS_IDLE;
					irq_set[IRQ_PASS] = 1'b1;
				end else if (tmr_done) begin
					state_d = VPS_PRESS;
					load_d = 1'b1;
				end
			end
			VPS_PRESS: begin
				if (tmr_done) begin
					state_d = VPS_SETTLE_HI;
					load_d = 1'b1;
					secs_d = SETTLE_S;
				end
			end
			VPS_SETTLE_HI: begin
				if (tmr_done) begin
					state_d = VPS_TEST_HI;
					load_d = 1'b1;
					secs_d = ttime_q;
				end
			end
			VPS_TEST_HI: begin
				if (!switch_s) begin
					state_d = VPS_LOCK;
					irq_set[IRQ_HIGH_LEAK] = 1'b1;
				end else if (tmr_done) begin
					irq_set[IRQ_PASS] = 1'b1;
					state_d = after_q ? VPS_IDLE : VPS_RUN;
				end
			end
			VPS_RUN: begin
				if (!demand_s) begin
					after_d = 1'b1;
					load_d = 1'b1;
					case (sched_q)
						VPS_AFTER, VPS_BOTH,
						VPS_SPLIT: state_d = VPS_DEPRESS;
						default: state_d = VPS_IDLE;
					endcase
				end
			end
			VPS_LOCK: begin
				if (clr_lock) begin
					state_d = VPS_IDLE;
				end
			end
			default: state_d = VPS_IDLE;
		endcase
		// losing demand during the pre-run test abandons it safely
		if (!after_q && !demand_s && state_q != VPS_LOCK &&
			state_q != VPS_IDLE && state_q != VPS_RUN &&
			state_d != VPS_LOCK) begin
			state_d = VPS_IDLE;
			load_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= VPS_IDLE;
			after_q <= 1'b0;
		end else begin
			state_q <= state_d;
			after_q <= after_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			load_q <= 1'b0;
			secs_q <= PULSE_S;
		end else begin
			load_q <= load_d;
			secs_q <= secs_d;
		end
	end

	// ------------------------------------------------------------------
	// registered outputs, decoded from the next state
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			valves <= '0;
		end else begin
			valves.downstream_valve <= state_d == VPS_DEPRESS;
			valves.upstream_valve <= state_d == VPS_PRESS;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lockout <= 1'b0;
			proving_busy <= 1'b0;
			run_permit <= 1'b0;
			safety_relay_hold <= 1'b0;
		end else begin
			lockout <= state_d == VPS_LOCK;
			proving_busy <= state_d != VPS_IDLE && state_d != VPS_RUN &&
				state_d != VPS_LOCK;
			run_permit <= state_d == VPS_RUN;
			// keep the safety relay in until the after-run test ends
			safety_relay_hold <= state_d == VPS_RUN ||
				(proving_busy && after_d) || (state_d != VPS_IDLE &&
				state_d != VPS_LOCK);
		end
	end

	// ------------------------------------------------------------------
	// interval timer
	// ------------------------------------------------------------------
	vps_timer #(
		.CYC_SEC(CYC_SEC)
	) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.load(load_q),
		.secs(secs_q),
		.done(tmr_done)
	);

endmodule : vps_seq

// >>> testbench/vps_seq_checker.sv
// port checker for the valve proving sequencer.
// assumes one clock core_clk and active-high async rst.
`timescale 1ns/1ps
module vps_seq_checker
	import vps_pkg::*;
#(
	parameter longint unsigned CYC_SEC = CYC_PER_SEC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic demand,
	input wire vps_valve_s valves,
	input wire logic lockout,
	input wire logic proving_busy,
	input wire logic run_permit
);
	// ------------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------------
	// ten percent band plus a few cycles of phase overhead
	localparam longint unsigned P_LO = CYC_SEC * 36 / 10;
	localparam longint unsigned P_HI = CYC_SEC * 44 / 10 + 4;
	localparam longint unsigned S_LO = CYC_SEC * 27 / 10;
	int unsigned dn_cnt;
	int unsigned up_cnt;
	int unsigned gap;
	logic dn;
	logic up;
	logic clr;
	assign dn = valves.downstream_valve;
	assign up = valves.upstream_valve;
	assign clr = psel && penable && pwrite && paddr == CTRL_OFS
		&& pwdata[CTRL_CLR_BIT];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dn_cnt <= 0;
			up_cnt <= 0;
			gap <= 0;
		end else begin
			dn_cnt <= (dn && !up) ? dn_cnt + 1 : 0;
			up_cnt <= (up && !dn) ? up_cnt + 1 : 0;
			gap <= (dn_cnt != 0 && !dn) || (up_cnt != 0 && !up) ? 0 : gap + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	AST_PULSE_DN: assert property ($fell(dn) && !up && proving_busy
		|-> dn_cnt >= P_LO && dn_cnt <= P_HI) else $error("dn pulse length");
	AST_PULSE_UP: assert property ($fell(up) && !dn && proving_busy
		|-> up_cnt >= P_LO && up_cnt <= P_HI) else $error("up pulse length");
	AST_SETTLE: assert property ($rose(lockout) |-> gap >= S_LO)
		else $error("switch seen during settle");
	AST_LOCK_HOLD: assert property (lockout && !clr |=> lockout)
		else $error("lockout dropped without clear");
	AST_LOCK_VALVES: assert property (lockout && $past(lockout)
		|-> valves == '0) else $error("valve on in lockout");
	AST_EXCL: assert property (proving_busy && $past(proving_busy)
		|-> !(up && dn)) else $error("both valves on while proving");
	AST_DEMAND: assert property ($rose(proving_busy) && !$past(run_permit)
		&& !$past(run_permit, 2) |-> $past(demand, 3))
		else $error("proving without demand");
	AST_PERMIT: assert property (run_permit |-> !proving_busy && !lockout)
		else $error("run while proving");
	AST_IDLE: assert property (!proving_busy && !run_permit
		&& $past(!proving_busy && !run_permit) |-> valves == '0)
		else $error("valve on while idle");
endmodule : vps_seq_checker

bind vps_seq vps_seq_checker #(.CYC_SEC(CYC_SEC)) u_chk (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .demand(demand),
	.valves(valves), .lockout(lockout), .proving_busy(proving_busy),
	.run_permit(run_permit)
);

// >>> testbench/vps_gas_model.sv
// gas train model: two seats and the interspace pressure switch.
// assumes valve drives are high to energize; leaks are bench commands.
`timescale 1ns/1ps
module vps_gas_model
	import vps_pkg::*;
(
	input wire logic core_clk,
	input wire vps_valve_s valves,
	input wire logic leak_up,
	input wire logic leak_dn,
	output logic seat_pressure_switch = 1'b0
);
	// trapped gas holds its pressure unless a seat opens or leaks
	always @(posedge core_clk) begin
		if (valves.downstream_valve || leak_dn && !valves.upstream_valve)
			seat_pressure_switch <= 1'b0;
		else if (valves.upstream_valve || leak_up)
			seat_pressure_switch <= 1'b1;
	end
endmodule : vps_gas_model

// >>> testbench/vps_seq_test.sv
// self-checking bench for the valve proving sequencer.
// assumes apb slave at 200 MHz and the gas model on the far side.
`timescale 1ns/1ps
module vps_seq_test;
	import vps_pkg::*;
	// ------------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------------
	localparam longint unsigned CS = 20;
	localparam logic [15:0] EXP [5] = '{16'h0, 16'h1100, 16'h0011,
		16'h1111, 16'h0110};
	localparam int ET [5] = '{0, 360, 360, 720, 360};
	localparam logic [31:0] TT [4] = '{32'h003d003c, 32'h025d0258,
		32'h04d204b0, 32'h13880e10};
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, demand = 0, sw, lockout, busy, permit;
	logic hold, irq, leak_up = 0, leak_dn = 0, after_run = 0, dn_q, up_q;
	logic [2:0] flg;
	logic [15:0] cnt;
	vps_valve_s valves;
	int n_errors = 0, samples_checked = 0, n, bcnt;
	assign flg = {lockout, busy, permit};
	always #2.5 core_clk = ~core_clk;
	vps_seq #(.CYC_SEC(CS)) u_dut (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .demand(demand), .seat_pressure_switch(sw),
		.valves(valves), .lockout(lockout), .proving_busy(busy),
		.run_permit(permit), .safety_relay_hold(hold), .irq(irq));
	vps_gas_model u_gas (.core_clk(core_clk), .valves(valves),
		.leak_up(leak_up), .leak_dn(leak_dn), .seat_pressure_switch(sw));
	// pulse counts before and after run, one nibble each
	always @(posedge core_clk) begin
		dn_q <= valves.downstream_valve;
		up_q <= valves.upstream_valve;
		if (busy)
			bcnt <= bcnt + 1;
		if (permit)
			after_run <= 1;
		if (busy && valves.downstream_valve && !dn_q)
			cnt[(after_run ? 4 : 12) +: 4] <= cnt[(after_run ? 4 : 12) +: 4] + 1;
		if (busy && valves.upstream_valve && !up_q)
			cnt[(after_run ? 0 : 8) +: 4] <= cnt[(after_run ? 0 : 8) +: 4] + 1;
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		// no wait-state limit here; the watchdog ends a hung transfer
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task till(input int s, input logic v);
		n = 0;
		do @(posedge core_clk); while (flg[s] !== v && ++n < 4000);
		chk("wait bound", 1, n < 4000);
	endtask : till
	task conclude;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 0;
		apb(0, CTRL_OFS, 0);
		chk("ctrl reset", 0, rd);
		apb(0, TTIME_OFS, 0);
		chk("ttime reset", {20'h0, TTIME_RST}, rd);
		apb(0, 8'h20, 0);
		chk("unmapped err", 1, err);
		foreach (TT[i]) begin
			apb(1, TTIME_OFS, TT[i][31:16]);
			apb(0, TTIME_OFS, 0);
			chk("ttime snap", TT[i][15:0], rd);
		end
		apb(1, TTIME_OFS, 2);
		for (int i = 0; i < 5; i++) begin
			apb(1, CTRL_OFS, i);
			cnt <= 0;
			bcnt <= 0;
			after_run <= 0;
			demand <= 1;
			till(0, 1);
			chk("relay hold", 1, hold);
			demand <= 0;
			repeat (20) @(posedge core_clk);
			chk("relay after", i >= 2, hold);
			till(1, 0);
			chk("pulses", EXP[i], cnt);
			chk("span", 1, bcnt <= ET[i] * 11 / 10 + 8 && bcnt >= ET[i] * 9 / 10);
			chk("irq masked", 0, irq);
		end
		demand <= 1;
		repeat (100) @(posedge core_clk);
		demand <= 0;
		repeat (20) @(posedge core_clk);
		chk("abort idle", 0, {busy, lockout, valves});
		apb(1, CTRL_OFS, 1);
		apb(1, IRQ_MASK_OFS, 7);
		for (int k = 0; k < 2; k++) begin
			apb(0, IRQ_STAT_OFS, 0);
			leak_up <= k == 0;
			leak_dn <= k == 1;
			demand <= 1;
			till(2, 1);
			repeat (100) @(posedge core_clk);
			chk("lock valves", 0, {lockout, valves} ^ 3'h4);
			chk("irq raised", 1, irq);
			apb(0, IRQ_STAT_OFS, 0);
			chk("leak cause", k ? 2 : 1, rd);
			@(posedge core_clk);
			chk("irq cleared", 0, irq);
			demand <= 0;
			leak_up <= 0;
			leak_dn <= 0;
			// let the synced demand fall first, or the clear restarts a test
			repeat (6) @(posedge core_clk);
			apb(1, CTRL_OFS, 32'h101);
			repeat (2) @(posedge core_clk);
			chk("lock cleared", 0, lockout);
		end
		conclude();
	end
endmodule : vps_seq_test
